/* rtl/pin_level_sync.sv */
// Two flip-flop synchroniser for asynchronous pin and comparator levels.
`timescale 1ns/1ps
`default_nettype none

module pin_level_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] async_level,
  output logic [WIDTH-1:0] sync_level
);

  // ---------------------------------------------------------------
  // Synchroniser stages
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // The first stage is read only by the second one.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_level;
      sync_q <= meta_q;
    end
  end

  assign sync_level = sync_q;

endmodule

`default_nettype wire

/* rtl/port_a_pin_control.sv */
// Port A pin control: direction, latch, pin read path and overrides.
`timescale 1ns/1ps
`default_nettype none

// Function
// (RQ1) Output mode drives latch, analog irrelevant.
// (RQ2) Input mode reads pin; analog disables input.
// (RQ3) Pins 0-3 reset to analog inputs.
// (RQ4) Reference output disables pin 2 digital.
// (RQ5) Pin 2 input off under analog function.
// (RQ6) Pin 4 digital Schmitt input by default.
// (RQ7) Comparator outputs override latch on pins 4,5.
// (RQ8) Pin 5 resets to analog channel four.
// (RQ9) Pin 6 I/O only in I/O modes.
// (RQ10) Pin 6 drives quarter-rate cycle clock.
// (RQ11) Pin 7 off in external oscillator modes.
// (RQ12) Unused pins 6,7 read zero everywhere.
// (RQ13) Direction ignored for oscillator/reference functions.
// (RQ14) Latch register reads stored latch value.
// (RQ15) Unimplemented configuration bits read zero.
// (RQ16) Port read gives pins, write sets latch.
// (RQ17) Analog pins read zero through port.
// (RQ18) Direction resets to all inputs.
module port_a_pin_control
  import port_a_pkg::*;
#(
  parameter int PINS = 8
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [ADDR_W-1:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe,
  input wire logic [1:0] cmp_result,
  output logic [PINS-1:0] analog_select
);

  // ---------------------------------------------------------------
  // Registers and internal signals
  // ---------------------------------------------------------------
  logic [7:0] dir_q;
  logic [7:0] latch_q;
  logic [7:0] analog_cfg_q;
  logic [7:0] cmp_ctrl_q;
  logic [7:0] ref_ctrl_q;
  osc_mode_type osc_mode_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [PINS-1:0] out_q;
  logic [PINS-1:0] oe_q;
  logic [PINS-1:0] ana_q;
  logic [1:0] div_q;
  logic cyc_clk_q;
  logic [PINS+1:0] sync_all;
  logic [PINS-1:0] pin_sync;
  logic [1:0] cmp_sync;
  logic pin6_io;
  logic pin6_clk;
  logic pin7_io;
  logic [PINS-1:0] io_ok;
  logic cmp_on;
  logic cmp_route;
  logic ref_out;
  logic [PINS-1:0] analog;
  logic [PINS-1:0] in_en;
  logic [PINS-1:0] level;
  logic [PINS-1:0] out_d;
  logic [PINS-1:0] oe_d;
  logic req;
  logic wr;
  logic [7:0] rd_byte;

  // Channel k is analog while the select field is below its limit.
  function automatic logic adc_analog(input logic [3:0] sel, input int idx);
    logic [3:0] limit;
    limit = ANA_LIMIT_BASE - 4'(idx);
    return sel < limit;
  endfunction

  // ---------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------
  pin_level_sync #(
    .WIDTH(PINS + 2)
  ) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .async_level({cmp_result, pin_in}),
    .sync_level(sync_all)
  );

  assign pin_sync = sync_all[PINS-1:0];
  assign cmp_sync = sync_all[PINS+1:PINS];

  // ---------------------------------------------------------------
  // Oscillator pin use
  // ---------------------------------------------------------------
  // Decode which oscillator pins are free for general I/O.
  always_comb begin
    pin6_io = 1'b0;
    pin6_clk = 1'b0;
    pin7_io = 1'b0;
    unique case (osc_mode_q)
      ext_crystal_mode: begin
        pin6_io = 1'b0;
      end
      rc_clock_out_mode, ext_clock_out_mode: begin
        pin6_clk = 1'b1;
      end
      rc_with_io_mode, external_clock_with_io_mode: begin
        pin6_io = 1'b1;
      end
      internal_osc_clock_out_mode: begin
        pin6_clk = 1'b1;
        pin7_io = 1'b1;
      end
      internal_osc_with_io_mode: begin
        pin6_io = 1'b1;
        pin7_io = 1'b1;
      end
      default: begin
        pin6_io = 1'b0;
      end
    endcase
  end

  // (RQ9) pin 6 I/O gating.
  // (RQ11) pin 7 oscillator gating.
  assign io_ok = {pin7_io, pin6_io, LOW_PINS_IO};

  // ---------------------------------------------------------------
  // Analog selection
  // ---------------------------------------------------------------
  assign cmp_on = cmp_ctrl_q[CMP_MODE_HI:0] != CMP_OFF_MODE;
  assign cmp_route = cmp_ctrl_q[CMP_MODE_HI:0] == CMP_ROUTE_MODE;
  assign ref_out = ref_ctrl_q[REF_EN_BIT] & ref_ctrl_q[REF_OE_BIT];

  // Work out which pins are taken by an analog function.
  always_comb begin
    analog = '0;
    // (RQ3) low pins analog from reset config.
    for (int k = 0; k < PIN_CMP1; k++) begin
      analog[k] = adc_analog(analog_cfg_q[SELECT_HI:0], k) | cmp_on;
    end
    // (RQ5) reference inputs count as analog.
    analog[PIN_REF] = analog[PIN_REF] | analog_cfg_q[VREF_LO_BIT];
    analog[PIN_VREF_HI] = analog[PIN_VREF_HI] | analog_cfg_q[VREF_HI_BIT];
    // (RQ8) pin 5 carries channel four.
    analog[PIN_CMP2] = adc_analog(analog_cfg_q[SELECT_HI:0], CH4_INDEX);
    // (RQ6) pin 4 never analog.
    analog[PIN_CMP1] = 1'b0;
  end

  // ---------------------------------------------------------------
  // Pin read path
  // ---------------------------------------------------------------
  // (RQ2) analog pins lose their digital input.
  // (RQ4) reference output blocks pin 2 input.
  always_comb begin
    in_en = io_ok & ~analog;
    if (ref_out) begin
      in_en[PIN_REF] = 1'b0;
    end
  end

  // (RQ17) analog pins read as zero.
  assign level = pin_sync & in_en;

  // ---------------------------------------------------------------
  // Pin drive path
  // ---------------------------------------------------------------
  // Choose the value and enable for each pin driver.
  always_comb begin
    // (RQ1) output mode drives the latch.
    oe_d = ~dir_q & io_ok;
    out_d = latch_q & io_ok;
    // (RQ7) comparator results take priority.
    if (cmp_route && !dir_q[PIN_CMP1]) begin
      out_d[PIN_CMP1] = cmp_sync[0];
    end
    if (cmp_route && !dir_q[PIN_CMP2]) begin
      out_d[PIN_CMP2] = cmp_sync[1];
    end
    // (RQ13) direction ignored for these functions.
    if (ref_out) begin
      oe_d[PIN_REF] = 1'b0;
      out_d[PIN_REF] = 1'b0;
    end
    // (RQ10) cycle clock out on pin 6.
    if (pin6_clk) begin
      oe_d[PIN_CLK] = 1'b1;
      out_d[PIN_CLK] = cyc_clk_q;
    end
  end

  // Register the pin drivers and the analog selection.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      out_q <= '0;
      oe_q <= '0;
      ana_q <= '0;
    end else begin
      out_q <= out_d;
      oe_q <= oe_d;
      ana_q <= analog;
    end
  end

  assign pin_out = out_q;
  assign pin_oe = oe_q;
  assign analog_select = ana_q;

  // ---------------------------------------------------------------
  // Cycle clock divider
  // ---------------------------------------------------------------
  // Toggle every half period to give a quarter of the system clock.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      div_q <= '0;
      cyc_clk_q <= 1'b0;
    end else if (div_q == 2'(CYCLE_HALF - 1)) begin
      div_q <= '0;
      cyc_clk_q <= ~cyc_clk_q;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------
  assign req = wb_cyc & wb_stb;
  assign wr = req & wb_we & ack_q & wb_sel[0];

  // Acknowledge one cycle after the request, then drop for a cycle.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Read multiplexer; unmapped addresses return zero.
  always_comb begin
    rd_byte = 8'h00;
    unique case (wb_adr)
      // (RQ16) port read gives pin levels.
      OFS_PIN_LEVELS: rd_byte = level;
      // (RQ14) latch reads stored value.
      // (RQ12) unused oscillator pins read zero.
      OFS_OUTPUT_LATCH: rd_byte = latch_q & io_ok;
      OFS_DIRECTION: rd_byte = dir_q & io_ok;
      // (RQ15) upper config bits read zero.
      OFS_ANALOG_CFG: rd_byte = analog_cfg_q & CFG_IMPL_MASK;
      OFS_CMP_CTRL: rd_byte = {cmp_sync[1], cmp_sync[0], cmp_ctrl_q[CMP_KEEP_HI:0]};
      OFS_REF_CTRL: rd_byte = ref_ctrl_q;
      OFS_OSC_MODE: rd_byte = {5'h00, osc_mode_q};
      default: rd_byte = 8'h00;
    endcase
  end

  // Capture read data as the acknowledge rises.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rdata_q <= '0;
    end else if (req && !ack_q) begin
      rdata_q <= {24'h000000, rd_byte};
    end
  end

  assign wb_dat_r = rdata_q;
  assign wb_ack = ack_q;

  // ---------------------------------------------------------------
  // Port registers
  // ---------------------------------------------------------------
  // (RQ18) direction resets to inputs.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      dir_q <= DIR_RESET;
    end else if (wr && wb_adr == OFS_DIRECTION) begin
      dir_q <= wb_dat_w[7:0];
    end
  end

  // (RQ16) port and latch writes both set the latch.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      latch_q <= LATCH_RESET;
    end else if (wr && (wb_adr == OFS_OUTPUT_LATCH || wb_adr == OFS_PIN_LEVELS)) begin
      latch_q <= wb_dat_w[7:0];
    end
  end

  // Analog, comparator and reference configuration.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      analog_cfg_q <= ANALOG_CFG_RESET;
      cmp_ctrl_q <= CMP_CTRL_RESET;
      ref_ctrl_q <= REF_CTRL_RESET;
    end else if (wr) begin
      if (wb_adr == OFS_ANALOG_CFG) begin
        analog_cfg_q <= wb_dat_w[7:0] & CFG_IMPL_MASK;
      end
      if (wb_adr == OFS_CMP_CTRL) begin
        cmp_ctrl_q <= wb_dat_w[7:0];
      end
      if (wb_adr == OFS_REF_CTRL) begin
        ref_ctrl_q <= wb_dat_w[7:0];
      end
    end
  end

  // Oscillator configuration.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      osc_mode_q <= OSC_MODE_RESET;
    end else if (wr && wb_adr == OFS_OSC_MODE) begin
      osc_mode_q <= osc_mode_type'(wb_dat_w[2:0]);
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // (RQ18) direction after reset.
  a_dir_after_reset: assert property ($rose(nrst) |-> dir_q == DIR_RESET) // RQ18
    else $error("direction not all inputs after reset");

  // (RQ1) pin 0 in input mode never drives.
  a_input_no_drive: assert property (dir_q[0] |=> !pin_oe[0]) // RQ1
    else $error("pin 0 driven while input");

  // (RQ4) reference output releases pin 2.
  a_ref_release_pin: assert property (ref_out |=> !pin_oe[PIN_REF]) // RQ4
    else $error("pin 2 driven under reference output");

  // (RQ7) comparator result wins.
  a_cmp_priority: assert property (cmp_route && !dir_q[PIN_CMP1]
    |=> pin_oe[PIN_CMP1] && pin_out[PIN_CMP1] == $past(cmp_sync[0])) // RQ7
    else $error("comparator 1 result not on pin 4");

  // (RQ10) clock output ignores direction.
  a_clk_out_pin: assert property (pin6_clk |=> pin_oe[PIN_CLK]) // RQ10
    else $error("pin 6 not driving cycle clock");

  // (RQ11) pin 7 silent in external modes.
  a_osc_pin_quiet: assert property (!pin7_io |=> !pin_oe[PIN_OSC]) // RQ11
    else $error("pin 7 driven in oscillator mode");

  // (RQ17) analog pins read zero.
  a_analog_read_zero: assert property (req && !ack_q && !wb_we
    && wb_adr == OFS_PIN_LEVELS && analog[0] |=> wb_ack && !wb_dat_r[0]) // RQ17
    else $error("analog pin read as one");

  // (RQ15) unused config bits zero.
  a_cfg_upper_zero: assert property (req && !ack_q && !wb_we
    && wb_adr == OFS_ANALOG_CFG |=> wb_dat_r[7:6] == 2'h0) // RQ15
    else $error("analog config upper bits not zero");

  // (RQ14) latch write reaches the latch register.
  a_latch_write: assert property (wr && wb_adr == OFS_OUTPUT_LATCH
    |=> latch_q == $past(wb_dat_w[7:0])) // RQ14
    else $error("latch write lost");

  // Bus acknowledge lasts one cycle.
  a_ack_single: assert property (wb_ack |=> !wb_ack)
    else $error("acknowledge held too long");

  // (RQ12) unused pin 6 reads zero.
  a_pin6_dir_zero: assert property (req && !ack_q && !wb_we
    && wb_adr == OFS_DIRECTION && !pin6_io |=> !wb_dat_r[PIN_CLK]) // RQ12
    else $error("unused pin 6 direction read as one");

endmodule

`default_nettype wire

/* rtl/port_a_pkg.sv */
// Constants, register map and mode types for the port A pin control block.
package port_a_pkg;

  // ---------------------------------------------------------------
  // Register map, byte addresses on the Wishbone bus
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_PIN_LEVELS = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT_LATCH = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DIRECTION = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_ANALOG_CFG = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_CMP_CTRL = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_REF_CTRL = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_OSC_MODE = 8'h18;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] ANALOG_CFG_RESET = 8'h00;
  localparam logic [7:0] CMP_CTRL_RESET = 8'h07;
  localparam logic [7:0] REF_CTRL_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Field positions and codes
  // ---------------------------------------------------------------
  localparam int SELECT_HI = 3;
  localparam int VREF_HI_BIT = 4;
  localparam int VREF_LO_BIT = 5;
  localparam logic [7:0] CFG_IMPL_MASK = 8'h3f;
  localparam int CMP_MODE_HI = 2;
  localparam int CMP_KEEP_HI = 5;
  localparam int CMP_RES1_BIT = 6;
  localparam int CMP_RES2_BIT = 7;
  localparam logic [2:0] CMP_OFF_MODE = 3'h7;
  localparam logic [2:0] CMP_ROUTE_MODE = 3'h6;
  localparam int REF_OE_BIT = 6;
  localparam int REF_EN_BIT = 7;
  localparam logic [3:0] ANA_LIMIT_BASE = 4'h7;
  localparam int CH4_INDEX = 4;

  // Pin positions with special functions.
  localparam int PIN_REF = 2;
  localparam int PIN_VREF_HI = 3;
  localparam int PIN_CMP1 = 4;
  localparam int PIN_CMP2 = 5;
  localparam int PIN_CLK = 6;
  localparam int PIN_OSC = 7;
  localparam logic [5:0] LOW_PINS_IO = 6'h3f;

  // ---------------------------------------------------------------
  // Timing: the cycle clock runs at a quarter of the system clock
  // ---------------------------------------------------------------
  localparam int CLK_FREQ_MHZ = 200;
  localparam int CYCLE_CLK_DIV = 4;
  localparam int CYCLE_HALF = CYCLE_CLK_DIV / 2;

  // Oscillator configuration modes.
  typedef enum logic [2:0] {
    ext_crystal_mode,
    rc_clock_out_mode,
    rc_with_io_mode,
    internal_osc_clock_out_mode,
    internal_osc_with_io_mode,
    ext_clock_out_mode,
    external_clock_with_io_mode
  } osc_mode_type;

  localparam osc_mode_type OSC_MODE_RESET = internal_osc_with_io_mode;

endpackage

/* verification/pin_partner.sv */
// Far side of port A: external pin drivers and the two comparators.
`timescale 1ns/1ps
`default_nettype none

module pin_partner (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext_level,
  input wire logic [1:0] cmp_level,
  output logic [7:0] pin_in,
  output logic [1:0] cmp_result
);
  // ---------------------------------------------------------------
  // Pin levels
  // ---------------------------------------------------------------
  // A driven pin shows the device value, an undriven one the outside level.
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      pin_in[k] = pin_oe[k] ? pin_out[k] : ext_level[k];
    end
  end

  // Comparator results follow the analog levels chosen by the bench.
  assign cmp_result = cmp_level;
endmodule

`default_nettype wire

/* verification/port_a_pin_control_tb.sv */
// Self-checking testbench for the port A pin control block.
`timescale 1ns/1ps
`default_nettype none

module port_a_pin_control_tb;
  import port_a_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h00000000;
  logic [31:0] wb_dat_r;
  logic wb_ack;
  logic [7:0] pin_in, pin_out, pin_oe, analog_select;
  logic [7:0] ext_level = 8'hff;
  logic [1:0] cmp_level = 2'h0;
  logic [1:0] cmp_result;
  int errors = 0;
  int n_checks = 0;

  // Clock at 200 MHz.
  always #2.5 clk_sys = ~clk_sys;

  port_a_pin_control i_port_a_pin_control (.clk_sys(clk_sys), .nrst(nrst), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .cmp_result(cmp_result), .analog_select(analog_select));

  pin_partner i_pin_partner (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
    .cmp_level(cmp_level), .pin_in(pin_in), .cmp_result(cmp_result));

  // ---------------------------------------------------------------
  // Bus and compare helpers
  // ---------------------------------------------------------------
  // Classic single cycle, held until ack is sampled high.
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [7:0] wd,
    input logic [3:0] sel, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= sel;
    wb_dat_w <= {24'h000000, wd};
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    rd = wb_dat_r;
    if (n >= 50) begin
      errors++;
      $display("wrong value at %0t: no acknowledge", $time);
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
    logic [31:0] rd;
    wb_xfer(1'b1, adr, wd, 4'h1, rd);
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [7:0] exp, input string msg);
    logic [31:0] rd;
    wb_xfer(1'b0, adr, 8'h00, 4'h1, rd);
    chk(rd, {24'h000000, exp}, msg);
  endtask

  // Lets synchronisers and registered pin outputs settle.
  task automatic settle();
    repeat (5) @(posedge clk_sys);
    #1;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rd_chk(OFS_DIRECTION, 8'hff, "direction reset");
    rd_chk(OFS_OUTPUT_LATCH, 8'h00, "latch reset");
    rd_chk(OFS_ANALOG_CFG, 8'h00, "analog cfg reset");
    rd_chk(OFS_CMP_CTRL, 8'h07, "comparator reset");
    rd_chk(OFS_REF_CTRL, 8'h00, "reference reset");
    rd_chk(OFS_OSC_MODE, 8'h04, "osc mode reset");
    chk({24'h0, analog_select}, 32'h2f, "analog pins at reset");
    chk({24'h0, pin_oe}, 32'h00, "no drivers at reset");
    rd_chk(OFS_PIN_LEVELS, 8'hd0, "analog pins read zero");
    $display("test reset done");
  endtask

  task automatic t_registers();
    wr(OFS_ANALOG_CFG, 8'hcf);
    rd_chk(OFS_ANALOG_CFG, 8'h0f, "upper cfg bits read zero");
    wr(OFS_OUTPUT_LATCH, 8'ha5);
    wr(OFS_DIRECTION, 8'h00);
    settle();
    chk({pin_oe, pin_out}, 32'hffa5, "outputs follow latch");
    wr(OFS_DIRECTION, 8'hff);
    ext_level <= 8'h5a;
    settle();
    rd_chk(OFS_OUTPUT_LATCH, 8'ha5, "latch read not pins");
    rd_chk(OFS_PIN_LEVELS, 8'h5a, "port read gives pins");
    wr(OFS_PIN_LEVELS, 8'h3c);
    rd_chk(OFS_OUTPUT_LATCH, 8'h3c, "port write sets latch");
    wr(OFS_ANALOG_CFG, 8'h00);
    wr(OFS_DIRECTION, 8'h00);
    settle();
    chk({analog_select, pin_oe, pin_out}, 32'h2fff3c, "analog keeps outputs");
    wr(OFS_ANALOG_CFG, 8'h0f);
    $display("test registers done");
  endtask

  task automatic t_reference();
    wr(OFS_OUTPUT_LATCH, 8'hff);
    wr(OFS_REF_CTRL, 8'hc0);
    settle();
    chk({24'h0, pin_oe}, 32'hfb, "reference output stops pin 2 driver");
    wr(OFS_DIRECTION, 8'hff);
    ext_level <= 8'hff;
    settle();
    rd_chk(OFS_PIN_LEVELS, 8'hfb, "reference output stops pin 2 input");
    wr(OFS_REF_CTRL, 8'h00);
    wr(OFS_ANALOG_CFG, 8'h2f);
    settle();
    chk({24'h0, analog_select}, 32'h04, "pin 2 alone analog");
    rd_chk(OFS_PIN_LEVELS, 8'hfb, "analog pin 2 input off");
    wr(OFS_ANALOG_CFG, 8'h0f);
    $display("test reference done");
  endtask

  task automatic t_comparator();
    wr(OFS_OUTPUT_LATCH, 8'h00);
    wr(OFS_DIRECTION, 8'h00);
    wr(OFS_CMP_CTRL, 8'h06);
    cmp_level <= 2'h3;
    settle();
    chk({30'h0, pin_out[5:4]}, 32'h3, "comparators override latch");
    rd_chk(OFS_CMP_CTRL, 8'hc6, "results read in control");
    cmp_level <= 2'h1;
    settle();
    chk({30'h0, pin_out[5:4]}, 32'h1, "comparator results follow");
    wr(OFS_CMP_CTRL, 8'h07);
    cmp_level <= 2'h0;
    $display("test comparator done");
  endtask

  task automatic t_bus_edges();
    logic [31:0] rd;
    wr(8'h1c, 8'h55);
    rd_chk(8'h1c, 8'h00, "unmapped reads zero");
    wb_xfer(1'b1, OFS_OUTPUT_LATCH, 8'h77, 4'h0, rd);
    rd_chk(OFS_OUTPUT_LATCH, 8'h00, "write without lane 0 ignored");
    $display("test bus edges done");
  endtask

  task automatic t_osc_modes();
    logic io7, io6, ck;
    int cnt;
    logic prev;
    wr(OFS_OUTPUT_LATCH, 8'hff);
    wr(OFS_DIRECTION, 8'h00);
    // Code 7 is not a named mode and must behave like the crystal mode.
    for (int m = 0; m < 8; m++) begin
      io7 = (m == 3 || m == 4);
      io6 = (m == 2 || m == 4 || m == 6);
      ck = (m == 1 || m == 3 || m == 5);
      wr(OFS_OSC_MODE, m[7:0]);
      settle();
      chk({30'h0, pin_oe[7:6]}, {30'h0, io7, io6 | ck}, "osc pin drivers");
      cnt = 0;
      for (int c = 0; c < 8; c++) begin
        prev = pin_out[6];
        @(posedge clk_sys);
        #1;
        if (pin_out[6] !== prev) begin
          cnt++;
        end
      end
      if (ck) begin
        chk(cnt, 4, "cycle clock at quarter rate");
      end
      rd_chk(OFS_OUTPUT_LATCH, {io7, io6, 6'h3f}, "unused latch bits zero");
      rd_chk(OFS_PIN_LEVELS, {io7, io6, 6'h3f}, "unused pin bits zero");
      wr(OFS_DIRECTION, 8'hff);
      rd_chk(OFS_DIRECTION, {io7, io6, 6'h3f}, "unused direction bits zero");
      chk({30'h0, pin_oe[7:6]}, {30'h0, 1'b0, ck}, "clock out ignores direction");
      wr(OFS_DIRECTION, 8'h00);
    end
    $display("test oscillator modes done");
  endtask

  // A second reset in mid-run must bring back the direction, latch, oscillator mode and analog pin defaults.
  task automatic t_mid_reset();
    wr(OFS_OUTPUT_LATCH, 8'h5a);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    rd_chk(OFS_DIRECTION, 8'hff, "direction after second reset");
    rd_chk(OFS_OUTPUT_LATCH, 8'h00, "latch after second reset");
    rd_chk(OFS_OSC_MODE, 8'h04, "osc mode after second reset");
    chk({16'h0, analog_select, pin_oe}, 32'h2f00, "defaults after second reset");
    rd_chk(OFS_PIN_LEVELS, 8'hd0, "analog pins zero after second reset");
    $display("test mid-run reset done");
  endtask

  // ---------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    t_registers();
    t_reference();
    t_comparator();
    t_bus_edges();
    t_osc_modes();
    t_mid_reset();
    complete_run();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule

`default_nettype wire
